// file: gtm_params.svh
// Purpose: constants for the gated 16-bit timer
// Assumes: one ref_clk domain, AHB-Lite register access
// Notes: byte offsets of the register words and control bit positions
`ifndef GTM_PARAMS_SVH
`define GTM_PARAMS_SVH
`define GTM_OFS_CTRL 12'h000
`define GTM_OFS_GATE 12'h004
`define GTM_OFS_COUNT 12'h008
`define GTM_OFS_FLAGS 12'h00C
`define GTM_OFS_INTEN 12'h010
`define GTM_OFS_CCP 12'h014
`define GTM_OFS_CCPCTL 12'h018
`define GTM_B_RUN 0
`define GTM_B_NOSYNC 1
`define GTM_B_SLEEP 2
`define GTM_B_OSCEN 3
`define GTM_B_ENABLE 7
`define GTM_B_POL 6
`define GTM_B_TOGGLE 5
`define GTM_B_SPM 4
`define GTM_B_ARMED 3
`define GTM_B_LEVEL 2
`define GTM_B_GFLAG 0
`define GTM_B_RFLAG 1
`define GTM_B_GIE 0
`define GTM_B_RIE 1
`define GTM_B_PIE 2
`define GTM_B_GLOB 3
`define GTM_B_CCPMODE 0
`define GTM_B_CCPSPEC 1
`define GTM_B_CCPHIT 2
`define GTM_GSS_PIN 5'h00
`define GTM_GSS_LAST 5'h17
`define GTM_GSS_RSVD 5'h0F
`define GTM_COUNT_MAX 16'hFFFF
`define GTM_COUNT_ZERO 16'h0000
`endif

// file: gtm_pkg.sv
// Purpose: types shared by the gated timer
// Assumes: gtm_params.svh holds the numbers
// Notes: gate configuration word carried as one packed struct
package gtm_pkg;
  typedef struct packed {
    logic gateEnable;
    logic gatePolarity;
    logic gateToggleMode;
    logic gateSinglePulseMode;
    logic [4:0] gateSourceSelect;
  } gtm_gate_cfg_t;
  typedef enum logic [1:0] {
    GTM_SP_IDLE,
    GTM_SP_WAIT,
    GTM_SP_RUN
  } gtm_sp_state_t;
endpackage : gtm_pkg

// file: gtm_timer.sv
// Purpose: 16-bit gated up-counter with AHB-Lite registers
// Assumes: count clock arrives as a one-cycle enable; gate sources async
// Notes: gate sources pass a two-flop synchroniser before any use
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "gtm_params.svh"
// Summary of operation
// - gating enabled: count only while gate active, else count freely
// - polarity 1 counts on gate high, polarity 0 counts on gate low
// - active gate: advance one per count edge; inactive gate: hold
// - five-bit select picks pin, timer, ccp, pwm, comparator, logic sources
// - polarity applies to any source; own overflow, 01111 and 11000+ reserved
// - toggle mode routes gate through flop flipping on each rising edge
// - toggle flop forced to zero while toggle mode is off
// - set single pulse then armed; counting starts at next gate edge
// - armed clears on trailing gate edge; no further counting until rearmed
// - clearing single pulse mode also clears armed bit
// - toggle and single pulse together measure one whole gate cycle
// - read-only gate level shows latest gate level, even gating off
// - falling gate level sets gate flag; raises request if enabled
// - gate flag is set even while gating is disabled
// - count wraps FFFF to 0000 and sets the rollover flag
// - rollover request needs run, rollover, peripheral, global enables
// - in sleep count only async mode; rollover wakes if enabled
// - secondary oscillator keeps running in sleep regardless of nosync
// - capture event copies count into capture/compare pair
// - compare match of pair and count raises event, maybe special
module gtm_timer #(
  parameter int CW = 16,
  parameter int OWN_OVF_CODE = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic countTick,
  input wire logic asyncClockMode,
  input wire logic [23:0] gateSources,
  input wire logic captureEvent,
  output logic [CW-1:0] countValue,
  output logic gateIrq,
  output logic rolloverIrq,
  output logic wakeRequest,
  output logic compareEvent,
  output logic specialEventTrigger,
  output logic secondaryOscRun
);
  // gate sources arrive from other blocks and pins: synchronise
  logic [23:0] gateSync1;
  logic [23:0] gateSync2;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateSync1 <= '0;
      gateSync2 <= '0;
    end else begin
      gateSync1 <= gateSources;
      gateSync2 <= gateSync1;
    end
  end

  gtm_pkg::gtm_gate_cfg_t gateCfg;
  logic timerRunEnable;
  logic externalClockNosync;
  logic sleepMode;
  logic secondaryOscEnable;
  logic gatePulseArmed;
  logic gateEventFlag;
  logic rolloverFlag;
  logic gateEventIntEnable;
  logic rolloverIntEnable;
  logic peripheralIntEnable;
  logic globalIntEnable;
  logic ccpCompareMode;
  logic ccpSpecial;
  logic compareHit;
  logic [CW-1:0] capturePair;
  logic toggleFlop;
  logic gateLevelStatus;
  logic gateLevelPrev;
  logic rawPrev;
  gtm_pkg::gtm_sp_state_t spState;

  // source mux; reserved codes and own overflow read as idle low
  logic selRaw;
  always_comb begin
    selRaw = 1'b0;
    if (gateCfg.gateSourceSelect <= `GTM_GSS_LAST &&
        gateCfg.gateSourceSelect != `GTM_GSS_RSVD &&
        gateCfg.gateSourceSelect != 5'(OWN_OVF_CODE)) begin
      selRaw = gateSync2[gateCfg.gateSourceSelect];
    end
  end

  // polarity applied to the selected source
  logic polGate;
  assign polGate = gateCfg.gatePolarity ? selRaw : ~selRaw;

  // toggle flop flips on each rising (incrementing) edge of the gate
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) toggleFlop <= 1'b0;
    else if (!gateCfg.gateToggleMode) toggleFlop <= 1'b0;
    else if (polGate && !rawPrev) toggleFlop <= ~toggleFlop;
  end

  // one-cycle delayed copy of the polarised gate for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rawPrev <= 1'b0;
    else rawPrev <= polGate;
  end

  logic gateCtl;
  assign gateCtl = gateCfg.gateToggleMode ? toggleFlop : polGate;

  // single pulse: wait for rising gate edge, run until trailing edge
  logic gateRise;
  logic gateFall;
  assign gateRise = gateCtl && !gateLevelStatus;
  assign gateFall = !gateCtl && gateLevelStatus;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) spState <= gtm_pkg::GTM_SP_IDLE;
    else begin
      case (spState)
        gtm_pkg::GTM_SP_IDLE:
          if (gatePulseArmed) spState <= gtm_pkg::GTM_SP_WAIT;
        gtm_pkg::GTM_SP_WAIT:
          if (!gatePulseArmed) spState <= gtm_pkg::GTM_SP_IDLE;
          else if (gateRise) spState <= gtm_pkg::GTM_SP_RUN;
        gtm_pkg::GTM_SP_RUN:
          if (gateFall || !gatePulseArmed)
            spState <= gtm_pkg::GTM_SP_IDLE;
        default: spState <= gtm_pkg::GTM_SP_IDLE;
      endcase
    end
  end

  // level status register: latest gate control level, always valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateLevelStatus <= 1'b0;
      gateLevelPrev <= 1'b0;
    end else begin
      gateLevelStatus <= gateCtl;
      gateLevelPrev <= gateLevelStatus;
    end
  end
  logic gateLevelFall;
  assign gateLevelFall = gateLevelPrev && !gateLevelStatus;

  // count permission: single pulse only counts in its run window
  logic gateOpen;
  logic countAdvance;
  logic sleepAllowed;
  assign gateOpen = gateCfg.gateSinglePulseMode ?
                    (spState == gtm_pkg::GTM_SP_RUN && gateCtl) : gateCtl;
  assign sleepAllowed = !sleepMode || (asyncClockMode && externalClockNosync);
  assign countAdvance = timerRunEnable && countTick && sleepAllowed &&
                        (!gateCfg.gateEnable || gateOpen);
  logic wrap;
  assign wrap = countAdvance && countValue == `GTM_COUNT_MAX;

  // AHB-Lite address phase capture; single-cycle zero-wait slave
  logic wrPend;
  logic [11:0] wrAddr;
  logic rdAccept;
  assign rdAccept = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
    end else begin
      wrPend <= hsel && htrans[1] && hready && hwrite;
      wrAddr <= haddr;
    end
  end
  logic wCtrl;
  logic wGate;
  logic wCount;
  logic wFlags;
  logic wInten;
  logic wCcp;
  logic wCcpCtl;
  assign wCtrl = wrPend && wrAddr == `GTM_OFS_CTRL;
  assign wGate = wrPend && wrAddr == `GTM_OFS_GATE;
  assign wCount = wrPend && wrAddr == `GTM_OFS_COUNT;
  assign wFlags = wrPend && wrAddr == `GTM_OFS_FLAGS;
  assign wInten = wrPend && wrAddr == `GTM_OFS_INTEN;
  assign wCcp = wrPend && wrAddr == `GTM_OFS_CCP;
  assign wCcpCtl = wrPend && wrAddr == `GTM_OFS_CCPCTL;

  // control word: run, nosync, sleep, secondary oscillator enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timerRunEnable <= 1'b0;
      externalClockNosync <= 1'b0;
      sleepMode <= 1'b0;
      secondaryOscEnable <= 1'b0;
    end else if (wCtrl) begin
      timerRunEnable <= hwdata[`GTM_B_RUN];
      externalClockNosync <= hwdata[`GTM_B_NOSYNC];
      sleepMode <= hwdata[`GTM_B_SLEEP];
      secondaryOscEnable <= hwdata[`GTM_B_OSCEN];
    end
  end

  // oscillator runs on its enable alone, sleep and nosync do not stop it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) secondaryOscRun <= 1'b0;
    else secondaryOscRun <= secondaryOscEnable;
  end

  // gate configuration; select field lives in bits 12:8 of the same word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) gateCfg <= '0;
    else if (wGate) begin
      gateCfg.gateEnable <= hwdata[`GTM_B_ENABLE];
      gateCfg.gatePolarity <= hwdata[`GTM_B_POL];
      gateCfg.gateToggleMode <= hwdata[`GTM_B_TOGGLE];
      gateCfg.gateSinglePulseMode <= hwdata[`GTM_B_SPM];
      gateCfg.gateSourceSelect <= hwdata[12:8];
    end
  end

  // armed bit: software sets; trailing edge or mode clear drops it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) gatePulseArmed <= 1'b0;
    else if (wGate && !hwdata[`GTM_B_SPM]) gatePulseArmed <= 1'b0;
    else if (!gateCfg.gateSinglePulseMode) gatePulseArmed <= 1'b0;
    else if (wGate) gatePulseArmed <= hwdata[`GTM_B_ARMED];
    else if (spState == gtm_pkg::GTM_SP_RUN && gateFall)
      gatePulseArmed <= 1'b0;
  end

  // counter; a software write wins over a count tick
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) countValue <= `GTM_COUNT_ZERO;
    else if (wCount) countValue <= hwdata[CW-1:0];
    else if (ccpSpecial && compareHit) countValue <= `GTM_COUNT_ZERO;
    else if (countAdvance) countValue <= countValue + 1'b1;
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateEventFlag <= 1'b0;
      rolloverFlag <= 1'b0;
    end else begin
      if (gateLevelFall) gateEventFlag <= 1'b1;
      else if (wFlags && hwdata[`GTM_B_GFLAG]) gateEventFlag <= 1'b0;
      if (wrap) rolloverFlag <= 1'b1;
      else if (wFlags && hwdata[`GTM_B_RFLAG]) rolloverFlag <= 1'b0;
    end
  end

  // interrupt enables
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateEventIntEnable <= 1'b0;
      rolloverIntEnable <= 1'b0;
      peripheralIntEnable <= 1'b0;
      globalIntEnable <= 1'b0;
    end else if (wInten) begin
      gateEventIntEnable <= hwdata[`GTM_B_GIE];
      rolloverIntEnable <= hwdata[`GTM_B_RIE];
      peripheralIntEnable <= hwdata[`GTM_B_PIE];
      globalIntEnable <= hwdata[`GTM_B_GLOB];
    end
  end

  // request outputs are registered levels following the flags
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateIrq <= 1'b0;
      rolloverIrq <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      gateIrq <= gateEventFlag && gateEventIntEnable;
      rolloverIrq <= rolloverFlag && timerRunEnable && rolloverIntEnable &&
                     peripheralIntEnable && globalIntEnable;
      wakeRequest <= sleepMode && rolloverFlag && rolloverIntEnable &&
                     peripheralIntEnable;
    end
  end

  // capture/compare pair: capture copies the count, software may load it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) capturePair <= '0;
    else if (!ccpCompareMode && captureEvent) capturePair <= countValue;
    else if (wCcp) capturePair <= hwdata[CW-1:0];
  end

  // compare mode and special-event option
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ccpCompareMode <= 1'b0;
      ccpSpecial <= 1'b0;
    end else if (wCcpCtl) begin
      ccpCompareMode <= hwdata[`GTM_B_CCPMODE];
      ccpSpecial <= hwdata[`GTM_B_CCPSPEC];
    end
  end

  // match is combinational, the events are registered; one pulse per match entry
  assign compareHit = ccpCompareMode && capturePair == countValue;
  logic compareHitPrev;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      compareHitPrev <= 1'b0;
      compareEvent <= 1'b0;
      specialEventTrigger <= 1'b0;
    end else begin
      compareHitPrev <= compareHit;
      compareEvent <= compareHit && !compareHitPrev;
      specialEventTrigger <= compareHit && !compareHitPrev && ccpSpecial;
    end
  end

  // read data registered in the data phase; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hrdata <= '0;
    else if (rdAccept) begin
      case (haddr)
        `GTM_OFS_CTRL: hrdata <= {28'h0000000, secondaryOscEnable, sleepMode,
                                  externalClockNosync, timerRunEnable};
        `GTM_OFS_GATE: hrdata <= {19'h00000, gateCfg.gateSourceSelect,
                                  gateCfg.gateEnable, gateCfg.gatePolarity,
                                  gateCfg.gateToggleMode,
                                  gateCfg.gateSinglePulseMode,
                                  gatePulseArmed, gateLevelStatus, 2'h0};
        `GTM_OFS_COUNT: hrdata <= {16'h0000, countValue};
        `GTM_OFS_FLAGS: hrdata <= {30'h00000000, rolloverFlag, gateEventFlag};
        `GTM_OFS_INTEN: hrdata <= {28'h0000000, globalIntEnable,
                                   peripheralIntEnable, rolloverIntEnable,
                                   gateEventIntEnable};
        `GTM_OFS_CCP: hrdata <= {16'h0000, capturePair};
        `GTM_OFS_CCPCTL: hrdata <= {29'h00000000, compareHit, ccpSpecial,
                                    ccpCompareMode};
        default: hrdata <= '0;
      endcase
    end
  end

  // zero wait state, always OKAY
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // assertions: one clock domain, so clock and reset are given once
  default clocking asrtClk @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_hold_when_off: assert property (!timerRunEnable &&
    !wCount && !(ccpSpecial && compareHit)
    |=> countValue == $past(countValue))
    else $error("count moved while run enable clear");
  a_gate_hold: assert property (gateCfg.gateEnable && !gateOpen &&
    !wCount && !(ccpSpecial && compareHit)
    |=> countValue == $past(countValue))
    else $error("count moved while gate closed");
  a_count_step: assert property (countAdvance && !wCount &&
    !(ccpSpecial && compareHit)
    |=> countValue == $past(countValue) + 16'h0001)
    else $error("count did not advance by one");
  a_wrap_flag: assert property (wrap && !wCount &&
    !(ccpSpecial && compareHit)
    |=> countValue == `GTM_COUNT_ZERO && rolloverFlag)
    else $error("rollover not flagged");
  a_toggle_clear: assert property (!gateCfg.gateToggleMode |=>
    !toggleFlop)
    else $error("toggle flop not held clear");
  sequence s_level_drop;
    gateLevelStatus ##1 !gateLevelStatus;
  endsequence
  a_gate_flag: assert property (s_level_drop |=> gateEventFlag)
    else $error("gate flag missed falling level");
  a_armed_clear: assert property (!gateCfg.gateSinglePulseMode |=>
    !gatePulseArmed)
    else $error("armed bit survived single pulse off");
  a_roll_irq: assert property (rolloverIrq |->
    $past(rolloverFlag) && $past(timerRunEnable))
    else $error("rollover request without cause");
  a_capture: assert property (captureEvent && !ccpCompareMode |=>
    capturePair == $past(countValue))
    else $error("capture did not copy count");
endmodule : gtm_timer

// file: gtm_far_side.sv
// Purpose: far side of the gated timer: gate sources and capture unit
// Assumes: bench sets steady source levels and asks for timed pulses
// Notes: a pulse inverts one source for a set number of cycles
`timescale 1ns/1ps
module gtm_far_side (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [23:0] srcLevel,
  input wire logic pulseGo,
  input wire logic [4:0] pulseSrc,
  input wire logic [7:0] pulseLen,
  input wire logic capGo,
  output logic [23:0] gateSources,
  output logic captureEvent
);
  logic [7:0] left;
  logic [4:0] sel;
  // pulse timer; the length sets how many cycles the source stays inverted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      left <= 8'h00;
      sel <= 5'h00;
    end else if (pulseGo) begin
      left <= pulseLen;
      sel <= pulseSrc;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // source index equals the select code, pin at index zero
  always_comb begin
    gateSources = srcLevel;
    if (left != 8'h00) gateSources[sel] = ~srcLevel[sel];
  end
  // capture unit raises its configured event for one cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) captureEvent <= 1'b0;
    else captureEvent <= capGo;
  end
endmodule : gtm_far_side

// file: testbench.sv
// Purpose: directed bench for the gated timer over AHB-Lite
// Assumes: gate changes settle within six cycles of the synchroniser
// Notes: ticks are sent only while the gate stands still
`timescale 1ns/1ps
`include "gtm_params.svh"
module testbench;
  logic ref_clk, resetn, hsel, hwrite, countTick, asyncClockMode;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic hreadyout, hresp, captureEvent, pulseGo, capGo, cmpHit, spHit;
  logic gateIrq, rolloverIrq, wakeRequest, compareEvent;
  logic specialEventTrigger, secondaryOscRun, ok;
  logic [23:0] gateSources, srcLevel;
  logic [4:0] pulseSrc;
  logic [7:0] pulseLen;
  logic [15:0] countValue;
  int n_errors = 0;
  int n_compared = 0;
  gtm_timer #(.CW(16), .OWN_OVF_CODE(2)) DUT (.ref_clk(ref_clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .countTick(countTick), .asyncClockMode(asyncClockMode),
    .gateSources(gateSources), .captureEvent(captureEvent),
    .countValue(countValue), .gateIrq(gateIrq),
    .rolloverIrq(rolloverIrq), .wakeRequest(wakeRequest),
    .compareEvent(compareEvent),
    .specialEventTrigger(specialEventTrigger),
    .secondaryOscRun(secondaryOscRun));
  gtm_far_side far (.ref_clk(ref_clk), .resetn(resetn),
    .srcLevel(srcLevel), .pulseGo(pulseGo), .pulseSrc(pulseSrc),
    .pulseLen(pulseLen), .capGo(capGo), .gateSources(gateSources),
    .captureEvent(captureEvent));
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // event pulses last one cycle, so latch them for later checks
  always @(posedge ref_clk) begin
    if (compareEvent === 1'b1) cmpHit <= 1'b1;
    if (specialEventTrigger === 1'b1) spHit <= 1'b1;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // one single transfer; the address phase holds until hready is seen
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask : bus
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : w
  task automatic rc(input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rc
  task automatic ticks(input int n);
    repeat (n) begin
      countTick <= 1'b1;
      @(posedge ref_clk);
      countTick <= 1'b0;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
  endtask : ticks
  task automatic tk(input int n, input logic [15:0] e);
    ticks(n);
    chk({16'h0, countValue}, {16'h0, e});
  endtask : tk
  task automatic pulse(input logic [7:0] len);
    pulseGo <= 1'b1;
    pulseLen <= len;
    @(posedge ref_clk);
    pulseGo <= 1'b0;
    idle(len + 8);
  endtask : pulse
  function automatic logic [31:0] gw(input logic [4:0] f,
    input logic [4:0] s);
    gw = {19'h0, s, f, 3'h0};
  endfunction : gw
  // a hang is cut short well past the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {hsel, hwrite, countTick, asyncClockMode, pulseGo, capGo} = 6'h00;
    {cmpHit, spHit} = 2'h0;
    htrans = 2'h0;
    haddr = 12'h000;
    hsize = 3'h2;
    hwdata = 32'h0;
    srcLevel = 24'h0;
    pulseSrc = 5'h00;
    pulseLen = 8'h00;
    resetn = 1'b0;
    idle(6);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rc(`GTM_OFS_CTRL, 32'hF, 32'h0);
    rc(`GTM_OFS_GATE, 32'h1FFB, 32'h0);
    rc(`GTM_OFS_FLAGS, 32'h3, 32'h0);
    w(12'h040, 32'hFFFFFFFF);
    rc(12'h040, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    tk(4, 16'h0000);
    w(`GTM_OFS_CTRL, 32'h1);
    tk(5, 16'h0005);
    $display("test reset and run done");
    for (int i = 0; i < 8; i++) begin
      w(`GTM_OFS_GATE, gw({i[2], i[1], 3'h0}, 5'h00));
      srcLevel <= {23'h0, i[0]};
      idle(6);
      w(`GTM_OFS_COUNT, 32'h0);
      tk(3, (!i[2] || i[1] == i[0]) ? 16'h3 : 16'h0);
      rc(`GTM_OFS_GATE, 32'h4, {29'h0, i[1] == i[0], 2'h0});
    end
    $display("test polarity done");
    for (int c = 0; c < 32; c++) begin
      ok = c <= `GTM_GSS_LAST && c != `GTM_GSS_RSVD && c != 2;
      srcLevel <= (c < 24) ? 24'h1 << c : 24'h0;
      w(`GTM_OFS_GATE, gw(5'h18, c[4:0]));
      idle(6);
      w(`GTM_OFS_COUNT, 32'h0);
      tk(2, ok ? 16'h2 : 16'h0);
    end
    $display("test source select done");
    w(`GTM_OFS_GATE, gw(5'h08, 5'h00));
    srcLevel <= 24'h0;
    idle(6);
    w(`GTM_OFS_FLAGS, 32'h3);
    w(`GTM_OFS_INTEN, 32'h0);
    pulse(8'h04);
    rc(`GTM_OFS_FLAGS, 32'h1, 32'h1);
    chk({31'h0, gateIrq}, 32'h0);
    w(`GTM_OFS_INTEN, 32'h1);
    idle(3);
    chk({31'h0, gateIrq}, 32'h1);
    w(`GTM_OFS_FLAGS, 32'h1);
    idle(3);
    chk({31'h0, gateIrq}, 32'h0);
    $display("test gate event done");
    w(`GTM_OFS_GATE, gw(5'h18, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h1C, 5'h00));
    w(`GTM_OFS_COUNT, 32'h0);
    pulse(8'h03);
    tk(3, 16'h3);
    pulse(8'h03);
    tk(3, 16'h3);
    pulse(8'h03);
    w(`GTM_OFS_GATE, gw(5'h18, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h1C, 5'h00));
    idle(4);
    tk(3, 16'h3);
    $display("test toggle done");
    w(`GTM_OFS_GATE, gw(5'h1A, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h1B, 5'h00));
    rc(`GTM_OFS_GATE, 32'h8, 32'h8);
    w(`GTM_OFS_COUNT, 32'h0);
    tk(2, 16'h0);
    srcLevel <= 24'h1;
    idle(6);
    tk(3, 16'h3);
    srcLevel <= 24'h0;
    idle(6);
    rc(`GTM_OFS_GATE, 32'h8, 32'h0);
    srcLevel <= 24'h1;
    idle(6);
    tk(3, 16'h3);
    srcLevel <= 24'h0;
    idle(6);
    w(`GTM_OFS_GATE, gw(5'h1B, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h19, 5'h00));
    rc(`GTM_OFS_GATE, 32'h8, 32'h0);
    w(`GTM_OFS_GATE, gw(5'h1A, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h1E, 5'h00));
    w(`GTM_OFS_GATE, gw(5'h1F, 5'h00));
    w(`GTM_OFS_COUNT, 32'h0);
    pulse(8'h03);
    tk(2, 16'h2);
    pulse(8'h03);
    rc(`GTM_OFS_GATE, 32'h8, 32'h0);
    pulse(8'h03);
    tk(2, 16'h2);
    $display("test single pulse done");
    w(`GTM_OFS_GATE, 32'h0);
    w(`GTM_OFS_FLAGS, 32'h3);
    w(`GTM_OFS_COUNT, 32'h0);
    w(`GTM_OFS_INTEN, 32'h6);
    w(`GTM_OFS_COUNT, 32'hFFFE);
    tk(1, 16'hFFFF);
    rc(`GTM_OFS_FLAGS, 32'h2, 32'h0);
    tk(1, 16'h0000);
    idle(2);
    chk({31'h0, rolloverIrq}, 32'h0);
    w(`GTM_OFS_INTEN, 32'hE);
    idle(3);
    chk({31'h0, rolloverIrq}, 32'h1);
    w(`GTM_OFS_CTRL, 32'h0);
    idle(3);
    chk({31'h0, rolloverIrq}, 32'h0);
    rc(`GTM_OFS_FLAGS, 32'h2, 32'h2);
    w(`GTM_OFS_FLAGS, 32'h2);
    rc(`GTM_OFS_FLAGS, 32'h2, 32'h0);
    $display("test rollover done");
    w(`GTM_OFS_INTEN, 32'h0);
    w(`GTM_OFS_COUNT, 32'h1234);
    capGo <= 1'b1;
    @(posedge ref_clk);
    capGo <= 1'b0;
    idle(3);
    rc(`GTM_OFS_CCP, 32'hFFFF, 32'h1234);
    w(`GTM_OFS_CTRL, 32'h1);
    w(`GTM_OFS_COUNT, 32'h10);
    w(`GTM_OFS_CCP, 32'h12);
    w(`GTM_OFS_CCPCTL, 32'h1);
    tk(2, 16'h12);
    idle(2);
    chk({31'h0, cmpHit}, 32'h1);
    // move pair and count off the old match before arming the special event
    w(`GTM_OFS_CCP, 32'h21);
    w(`GTM_OFS_COUNT, 32'h20);
    w(`GTM_OFS_CCPCTL, 32'h3);
    idle(3);
    chk({31'h0, spHit}, 32'h0);
    ticks(1);
    idle(3);
    chk({31'h0, spHit}, 32'h1);
    chk({16'h0, countValue}, 32'h0);
    $display("test capture compare done");
    w(`GTM_OFS_CCPCTL, 32'h0);
    w(`GTM_OFS_COUNT, 32'h0);
    w(`GTM_OFS_CTRL, 32'h5);
    tk(3, 16'h0);
    w(`GTM_OFS_CTRL, 32'hD);
    idle(2);
    chk({31'h0, secondaryOscRun}, 32'h1);
    asyncClockMode <= 1'b1;
    w(`GTM_OFS_CTRL, 32'hF);
    tk(3, 16'h3);
    chk({31'h0, secondaryOscRun}, 32'h1);
    w(`GTM_OFS_INTEN, 32'h6);
    w(`GTM_OFS_COUNT, 32'hFFFF);
    tk(1, 16'h0);
    idle(2);
    chk({31'h0, wakeRequest}, 32'h1);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : testbench
